// ===== src/cpu_slice_defs.vh
// constants for the or, stack, rotate and set-bit execution slice
`ifndef CPU_SLICE_DEFS_VH
`define CPU_SLICE_DEFS_VH
// opcodes
`define OP_OR_A_DIR 8'h45
`define OP_OR_A_IND 7'h23
`define OP_OR_A_IMM 8'h44
`define OP_OR_D_A 8'h42
`define OP_OR_D_IMM 8'h43
`define OP_OR_C_BIT 8'h72
`define OP_OR_C_NBIT 8'hA0
`define OP_POP 8'hD0
`define OP_PUSH 8'hC0
`define OP_CALL_EXIT 8'h22
`define OP_INT_EXIT 8'h32
`define OP_ROT_L 8'h23
`define OP_ROT_LC 8'h33
`define OP_ROT_R 8'h03
`define OP_ROT_RC 8'h13
`define OP_SET_C 8'hD3
`define OP_SET_BIT 8'hD2
// direct address of the stack pointer and accumulator in the special register space
`define SFR_SP_ADDR 8'h81
`define SFR_ACC_ADDR 8'hE0
// reset values
`define SP_RESET 8'h07
`define ACC_RESET 8'h00
`define PC_RESET 16'h0000
`endif

// ===== src/bit_op_unit.v
// bit address decode and bit-level update of a byte
`timescale 1ns/100ps
`default_nettype none
module bit_op_unit (
  // bit address
  input wire [7:0] bit_addr,
  // byte holding the bit
  input wire [7:0] byte_in,
  // action: set the bit to one
  input wire set_one,
  // decoded byte address and bit index
  output reg [7:0] byte_addr,
  output reg [2:0] bit_idx,
  // selected bit value and updated byte
  output reg bit_val,
  output reg [7:0] byte_out
);
  // low half maps into ram 20h..2Fh, upper half into bit-addressable registers
  always @* begin
    bit_idx = bit_addr[2:0];
    if (bit_addr[7]) begin
      byte_addr = {bit_addr[7:3], 3'h0};
    end else begin
      byte_addr = {4'h2, bit_addr[6:3]};
    end
    bit_val = byte_in[bit_addr[2:0]];
    byte_out = byte_in;
    if (set_one) begin
      byte_out[bit_addr[2:0]] = 1'b1;
    end
  end
endmodule // bit_op_unit
`default_nettype wire

// ===== src/cpu_slice.v
// execution slice: or forms, push/pop, returns, rotations and set bit
// How it works
// - or into accumulator: direct 45h, indirect 46h/47h, immediate 44h; one cycle.
// - or into direct byte: from accumulator 42h, from immediate 43h (address then data).
// - or to carry sets carry on a one source; inverted form leaves source alone.
// - bit or encodings 72h and A0h, bit address follows, two cycles.
// - pop D0h reads ram at stack pointer, decrements it, writes destination, no flags.
// - pop into stack pointer decrements first, so the popped value wins.
// - push C0h increments stack pointer, then stores the direct byte there.
// - return 22h pops counter high then low, decrementing after each read.
// - interrupt return 32h pops counter likewise and signals priority release.
// - interrupt return restores nothing but counter and stack pointer.
// - after interrupt return one more instruction runs before a pending vector.
// - rotate left 23h moves bit 7 to bit 0, carry untouched.
// - rotate left through carry 33h: bit 7 to carry, old carry to bit 0.
// - rotate right 03h moves bit 0 to bit 7, carry untouched.
// - rotate right through carry 13h: bit 0 to carry, old carry to bit 7.
// - set carry D3h and set addressable bit D2h force a one, nothing else.
// - byte or writes the bitwise or, flags untouched.
// - or on a port reads the output latch, never the pins.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_slice_defs.vh"
module cpu_slice (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // instruction bytes from the fetch unit
  input wire instr_valid,
  input wire [7:0] opcode,
  input wire [7:0] operand1,
  input wire [7:0] operand2,
  // indirect index register contents (r0 or r1 chosen by the opcode)
  input wire [7:0] index_r0,
  input wire [7:0] index_r1,
  // interrupt controller status
  input wire int_pending,
  // data memory: internal ram and special registers, combinational read
  input wire [7:0] mem_rdata,
  // state and memory write outputs
  output reg [7:0] acc_out,
  output reg carry_out,
  output reg [7:0] stack_pointer_out,
  output reg [15:0] instruction_pointer_out,
  output reg mem_we,
  output reg [7:0] mem_waddr,
  output reg [7:0] mem_wdata,
  output reg [7:0] mem_raddr,
  output reg busy,
  output reg prio_release,
  output reg int_vector_ok
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  // state codes: idle, bit second cycle, return low byte, vector hold
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_BIT2 = 2'd1;
  localparam [1:0] ST_RET_LO = 2'd2;
  localparam [1:0] ST_HOLD = 2'd3;

  // architectural state and the pipelined write port
  reg [1:0] state_reg, state_next;
  reg [7:0] acc_reg, acc_next;
  reg carry_reg, carry_next;
  reg [7:0] sp_reg, sp_next;
  reg [15:0] ip_reg, ip_next;
  reg [7:0] ret_hi_reg, ret_hi_next;
  reg int_exit_reg, int_exit_next;
  reg [7:0] bit_opc_reg, bit_opc_next;
  reg [7:0] bit_addr_reg, bit_addr_next;
  reg we_next;
  reg [7:0] waddr_next, wdata_next, raddr_next;
  reg prio_next;

  // ----------------------------------------
  // operand fetch and decode
  // ----------------------------------------
  // direct reads of the accumulator or stack pointer come from core registers;
  // ports resolve to output latches in the memory map, not the pins
  function [7:0] dir_value;
    input [7:0] addr;
    input [7:0] acc;
    input [7:0] sp;
    input [7:0] mem;
    begin
      if (addr == `SFR_ACC_ADDR) begin
        dir_value = acc;
      end else if (addr == `SFR_SP_ADDR) begin
        dir_value = sp;
      end else begin
        dir_value = mem;
      end
    end
  endfunction

  // bit unit results
  wire [7:0] bit_byte_addr;
  wire bit_val;
  wire [7:0] bit_byte_new;
  wire [7:0] cur_bit_addr = (state_reg == ST_BIT2) ? bit_addr_reg : operand1;

  // bit address decode shared by the bit or and set forms
  bit_op_unit u_bit (
    .bit_addr(cur_bit_addr),
    .byte_in(dir_value(bit_byte_addr, acc_reg, sp_reg, mem_rdata)),
    .set_one(1'b1),
    .byte_addr(bit_byte_addr),
    .bit_idx(),
    .bit_val(bit_val),
    .byte_out(bit_byte_new)
  );

  // operand sources
  wire [7:0] src_dir = dir_value(operand1, acc_reg, sp_reg, mem_rdata);
  wire [7:0] ind_ptr = opcode[0] ? index_r1 : index_r0;
  // pointer arithmetic stays eight bits, so the stack wraps inside internal ram
  wire [7:0] sp_inc = sp_reg + 8'h01; // eight-bit wrap
  wire [7:0] sp_dec = sp_reg - 8'h01; // eight-bit wrap

  // read address steering: read data is used in this cycle, but the address reaches mem_raddr through a register one cycle later
  always @* begin
    raddr_next = operand1;
    if (state_reg == ST_BIT2 || state_reg == ST_RET_LO) begin
      raddr_next = (state_reg == ST_BIT2) ? bit_byte_addr : sp_reg;
    end else if (instr_valid) begin
      case (opcode)
        `OP_POP, `OP_CALL_EXIT, `OP_INT_EXIT: raddr_next = sp_reg;
        {`OP_OR_A_IND, 1'b0}, {`OP_OR_A_IND, 1'b1}: raddr_next = ind_ptr;
        default: raddr_next = operand1;
      endcase
    end
  end

  // ----------------------------------------
  // execute
  // ----------------------------------------
  // main execute step
  always @* begin
    state_next = state_reg;
    acc_next = acc_reg;
    carry_next = carry_reg;
    sp_next = sp_reg;
    ip_next = ip_reg;
    ret_hi_next = ret_hi_reg;
    int_exit_next = int_exit_reg;
    bit_opc_next = bit_opc_reg;
    bit_addr_next = bit_addr_reg;
    we_next = 1'b0;
    waddr_next = 8'h00;
    wdata_next = 8'h00;
    prio_next = 1'b0;
    case (state_reg)
      ST_IDLE, ST_HOLD: begin
        // in hold the instruction at the return address still runs; only
        // vectoring waits until it has completed
        if (instr_valid) begin
          state_next = ST_IDLE;
          case (opcode)
            `OP_OR_A_DIR: acc_next = acc_reg | src_dir;
            {`OP_OR_A_IND, 1'b0}, {`OP_OR_A_IND, 1'b1}: acc_next = acc_reg | mem_rdata;
            `OP_OR_A_IMM: acc_next = acc_reg | operand1;
            `OP_OR_D_A: begin
              // latch value, not pins, is the old byte
              we_next = 1'b1;
              waddr_next = operand1;
              wdata_next = src_dir | acc_reg;
            end
            `OP_OR_D_IMM: begin
              we_next = 1'b1; // address then data byte
              waddr_next = operand1;
              wdata_next = src_dir | operand2;
            end
            `OP_OR_C_BIT, `OP_OR_C_NBIT, `OP_SET_BIT: begin
              // two-cycle bit forms: second cycle reads the addressed byte
              bit_opc_next = opcode;
              bit_addr_next = operand1;
              state_next = ST_BIT2;
            end
            `OP_POP: begin
              sp_next = sp_dec; // decrement then write, so sp target wins
              if (operand1 == `SFR_SP_ADDR) begin
                sp_next = mem_rdata;
              end else if (operand1 == `SFR_ACC_ADDR) begin
                acc_next = mem_rdata;
              end else begin
                we_next = 1'b1;
                waddr_next = operand1;
                wdata_next = mem_rdata;
              end
            end
            `OP_PUSH: begin
              sp_next = sp_inc; // increment first
              we_next = 1'b1;
              waddr_next = sp_inc;
              wdata_next = src_dir;
            end
            `OP_CALL_EXIT, `OP_INT_EXIT: begin
              ret_hi_next = mem_rdata; // high byte first
              sp_next = sp_dec;
              int_exit_next = (opcode == `OP_INT_EXIT);
              state_next = ST_RET_LO;
            end
            `OP_ROT_L: acc_next = {acc_reg[6:0], acc_reg[7]};
            `OP_ROT_LC: begin
              acc_next = {acc_reg[6:0], carry_reg};
              carry_next = acc_reg[7];
            end
            `OP_ROT_R: acc_next = {acc_reg[0], acc_reg[7:1]};
            `OP_ROT_RC: begin
              acc_next = {carry_reg, acc_reg[7:1]};
              carry_next = acc_reg[0];
            end
            `OP_SET_C: carry_next = 1'b1;
            default: ;
          endcase
        end
      end
      ST_BIT2: begin
        // second cycle: the addressed byte stands on the read data now
        state_next = ST_IDLE;
        case (bit_opc_reg)
          `OP_OR_C_BIT: carry_next = carry_reg | bit_val;
          `OP_OR_C_NBIT: carry_next = carry_reg | ~bit_val; // source left intact
          default: begin
            if (bit_byte_addr == `SFR_ACC_ADDR) begin
              acc_next = bit_byte_new;
            end else begin
              we_next = 1'b1;
              waddr_next = bit_byte_addr;
              wdata_next = bit_byte_new;
            end
          end
        endcase
      end
      ST_RET_LO: begin
        // low byte, second decrement; status word is never touched
        ip_next = {ret_hi_reg, mem_rdata};
        sp_next = sp_dec;
        prio_next = int_exit_reg;
        state_next = int_exit_reg ? ST_HOLD : ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // state registers; all outputs come from flip-flops
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      acc_reg <= `ACC_RESET;
      carry_reg <= 1'b0;
      sp_reg <= `SP_RESET;
      ip_reg <= `PC_RESET;
      ret_hi_reg <= 8'h00;
      int_exit_reg <= 1'b0;
      bit_opc_reg <= 8'h00;
      bit_addr_reg <= 8'h00;
      mem_we <= 1'b0;
      mem_waddr <= 8'h00;
      mem_wdata <= 8'h00;
      mem_raddr <= 8'h00;
      busy <= 1'b0;
      prio_release <= 1'b0;
      int_vector_ok <= 1'b0;
    end else begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      sp_reg <= sp_next;
      ip_reg <= ip_next;
      ret_hi_reg <= ret_hi_next;
      int_exit_reg <= int_exit_next;
      bit_opc_reg <= bit_opc_next;
      bit_addr_reg <= bit_addr_next;
      mem_we <= we_next;
      mem_waddr <= waddr_next;
      mem_wdata <= wdata_next;
      mem_raddr <= raddr_next;
      // busy covers the second cycle of the two-cycle forms
      busy <= (state_next == ST_BIT2) || (state_next == ST_RET_LO);
      prio_release <= prio_next;
      // hold after an interrupt return and any second cycle both keep vectoring off
      int_vector_ok <= int_pending & (state_next == ST_IDLE);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // architectural state mirrors
  always @* begin
    acc_out = acc_reg;
    carry_out = carry_reg;
    stack_pointer_out = sp_reg;
    instruction_pointer_out = ip_reg;
  end
endmodule // cpu_slice
`default_nettype wire

// ===== verif/cpu_slice_checker.sv
// port-level assertions for the execution slice
`timescale 1ns/100ps
`default_nettype none
`include "cpu_slice_defs.vh"
module cpu_slice_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // instruction and read data
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] mem_rdata,
  // state and strobes
  input wire logic [7:0] acc_out,
  input wire logic carry_out,
  input wire logic [7:0] stack_pointer_out,
  input wire logic busy,
  input wire logic prio_release,
  input wire logic mem_we,
  input wire logic [7:0] mem_waddr,
  input wire logic [7:0] mem_wdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // instr_valid is ignored mid-instruction, so only an idle cycle takes one
  wire take = instr_valid && !busy;
  // ----------------------------------------
  // instruction effects
  // ----------------------------------------
  a_or_imm: assert property (take && opcode == `OP_OR_A_IMM |=> acc_out == ($past(acc_out) | $past(operand1)))
    else $error("or immediate result wrong");
  a_push_sp: assert property (take && opcode == `OP_PUSH |=> stack_pointer_out == $past(stack_pointer_out) + 8'h01)
    else $error("push pointer wrong");
  a_push_store: assert property (take && opcode == `OP_PUSH && operand1 < 8'h80 |=> mem_we
    && mem_waddr == $past(stack_pointer_out) + 8'h01 && mem_wdata == $past(mem_rdata)) else $error("push store wrong");
  a_pop_sp: assert property (take && opcode == `OP_POP && operand1 != `SFR_SP_ADDR
    |=> stack_pointer_out == $past(stack_pointer_out) - 8'h01) else $error("pop pointer wrong");
  a_pop_self: assert property (take && opcode == `OP_POP && operand1 == `SFR_SP_ADDR
    |=> stack_pointer_out == $past(mem_rdata)) else $error("pop into pointer wrong");
  a_rot_left: assert property (take && opcode == `OP_ROT_L |=> acc_out == {$past(acc_out[6:0]), $past(acc_out[7])}
    && $stable(carry_out)) else $error("rotate left wrong");
  a_rot_lcarry: assert property (take && opcode == `OP_ROT_LC
    |=> {carry_out, acc_out} == {$past(acc_out), $past(carry_out)}) else $error("rotate left carry wrong");
  a_rot_right: assert property (take && opcode == `OP_ROT_R |=> acc_out == {$past(acc_out[0]), $past(acc_out[7:1])}
    && $stable(carry_out)) else $error("rotate right wrong");
  a_rot_rcarry: assert property (take && opcode == `OP_ROT_RC
    |=> {acc_out, carry_out} == {$past(carry_out), $past(acc_out)}) else $error("rotate right carry wrong");
  a_set_carry: assert property (take && opcode == `OP_SET_C |=> carry_out)
    else $error("set carry wrong");
  a_ret_sp: assert property (take && (opcode == `OP_CALL_EXIT || opcode == `OP_INT_EXIT)
    |=> busy ##1 stack_pointer_out == $past(stack_pointer_out, 2) - 8'h02) else $error("return pointer wrong");
  a_interrupt_exit_op_release: assert property (take && opcode == `OP_INT_EXIT |-> ##[1:3] prio_release)
    else $error("priority release missing");
endmodule // cpu_slice_checker
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the execution slice
`timescale 1ns/100ps
`default_nettype none
`include "cpu_slice_defs.vh"
module testbench;
  logic core_clk, sys_rst, instr_valid, int_pending, we_seen, rel_seen;
  logic [7:0] opcode, operand1, operand2, index_r0, index_r1, rd_addr, wa, wd;
  logic [7:0] ram [0:255];
  wire [7:0] acc_out, stack_pointer_out, mem_waddr, mem_wdata, mem_raddr;
  wire [15:0] instruction_pointer_out;
  wire carry_out, mem_we, busy, prio_release, int_vector_ok;
  // memory answers combinationally for the address each scenario expects
  wire [7:0] mem_rdata = ram[rd_addr];
  int mismatches, tests_run, cycles, lat;
  cpu_slice i_dut (.core_clk, .sys_rst, .instr_valid, .opcode, .operand1, .operand2, .index_r0, .index_r1,
    .int_pending, .mem_rdata, .acc_out, .carry_out, .stack_pointer_out, .instruction_pointer_out, .mem_we,
    .mem_waddr, .mem_wdata, .mem_raddr, .busy, .prio_release, .int_vector_ok);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // memory write-back, priority pulse catch and hang guard
  always @(posedge core_clk) begin
    if (mem_we === 1'b1) ram[mem_waddr] <= mem_wdata;
    if (prio_release === 1'b1) rel_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      end_sim();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [23:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one instruction; lat counts the extra edges of a two-cycle one
  task automatic issue(input logic [7:0] op, o1, o2, ra0, ra1);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    opcode <= op;
    operand1 <= o1;
    operand2 <= o2;
    rd_addr <= ra0;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    rd_addr <= ra1;
    #1;
    for (lat = 0; lat < 4 && busy === 1'b1; lat++) @(posedge core_clk) #1;
    we_seen = mem_we;
    wa = mem_waddr;
    wd = mem_wdata;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_or();
    issue(`OP_OR_A_IMM, 8'h41, 8'h00, 8'h41, 8'h41);
    chk("acc", 8'h41, acc_out);
    issue(`OP_OR_A_DIR, 8'h12, 8'h00, 8'h12, 8'h12);
    chk("acc", 8'h53, acc_out);
    issue({`OP_OR_A_IND, 1'b1}, 8'h00, 8'h00, 8'h24, 8'h24);
    chk("acc", 8'h77, acc_out);
    chk("raddr", 8'h24, mem_raddr);
    issue({`OP_OR_A_IND, 1'b0}, 8'h00, 8'h00, 8'h08, 8'h08);
    chk("acc", 8'h7F, acc_out);
    chk("carry", 1'b0, carry_out);
    issue(`OP_OR_D_A, 8'h40, 8'h00, 8'h40, 8'h40);
    chk("write", {8'h40, 8'h7F}, {wa, wd});
    issue(`OP_OR_D_IMM, 8'h11, 8'h80, 8'h11, 8'h11);
    chk("write", {8'h01, 8'h91}, {7'h00, we_seen, wd});
    chk("acc", 8'h7F, acc_out);
  endtask
  task automatic t_rot();
    logic [7:0] ops [5] = '{`OP_SET_C, `OP_ROT_L, `OP_ROT_LC, `OP_ROT_R, `OP_ROT_RC};
    logic [8:0] m;
    m = 9'h07F;
    foreach (ops[i]) begin
      issue(ops[i], 8'h00, 8'h00, 8'h00, 8'h00);
      case (ops[i])
        `OP_ROT_L: m[7:0] = {m[6:0], m[7]};
        `OP_ROT_LC: m = {m[7:0], m[8]};
        `OP_ROT_R: m[7:0] = {m[0], m[7:1]};
        `OP_ROT_RC: m = {m[0], m[8], m[7:1]};
        default: m[8] = 1'b1;
      endcase
      chk("carry_acc", {7'h00, m}, {7'h00, carry_out, acc_out});
    end
  endtask
  task automatic t_bit();
    issue(`OP_OR_C_NBIT, 8'h05, 8'h00, 8'h20, 8'h20);
    chk("carry", 1'b0, carry_out);
    issue(`OP_OR_C_BIT, 8'h00, 8'h00, 8'h20, 8'h20);
    chk("carry", 1'b0, carry_out);
    chk("cycles", 1, lat);
    issue(`OP_OR_C_NBIT, 8'h00, 8'h00, 8'h20, 8'h20);
    chk("carry_we", 2'b10, {carry_out, we_seen});
    issue(`OP_SET_BIT, 8'h0B, 8'h00, 8'h21, 8'h21);
    chk("set_bit", {1'b1, 8'h21, 8'h29}, {we_seen, wa, wd});
  endtask
  task automatic t_stack();
    issue(`OP_PUSH, 8'h12, 8'h00, 8'h12, 8'h12);
    chk("push", {8'h08, 8'h08, 8'h12}, {stack_pointer_out, wa, wd});
    issue(`OP_POP, 8'h33, 8'h00, 8'h08, 8'h08);
    chk("pop", {8'h07, 8'h33, 8'h12}, {stack_pointer_out, wa, wd});
    ram[8'h07] = 8'hFF;
    issue(`OP_POP, `SFR_SP_ADDR, 8'h00, 8'h07, 8'h07);
    chk("sp", 8'hFF, stack_pointer_out);
    issue(`OP_PUSH, 8'h12, 8'h00, 8'h12, 8'h12);
    chk("push_wrap", 16'h0000, {stack_pointer_out, wa});
    issue(`OP_POP, 8'h34, 8'h00, 8'h00, 8'h00);
    chk("sp", 8'hFF, stack_pointer_out);
  endtask
  task automatic t_ret();
    ram[8'hFF] = 8'h01;
    ram[8'hFE] = 8'h23;
    issue(`OP_CALL_EXIT, 8'h00, 8'h00, 8'hFF, 8'hFE);
    chk("ip", 16'h0123, instruction_pointer_out);
    chk("sp_cycles", {8'hFD, 8'h01}, {stack_pointer_out, lat[7:0]});
    ram[8'hFD] = 8'h45;
    ram[8'hFC] = 8'h67;
    int_pending <= 1'b1;
    rel_seen = 1'b0;
    issue(`OP_INT_EXIT, 8'h00, 8'h00, 8'hFD, 8'hFC);
    chk("ip", 16'h4567, instruction_pointer_out);
    chk("sp", 8'hFB, stack_pointer_out);
    chk("state", 9'h1FF, {carry_out, acc_out});
    @(posedge core_clk) #1;
    chk("release_vector", {rel_seen, int_vector_ok}, 2'b10);
    issue(`OP_PUSH, 8'h12, 8'h00, 8'h12, 8'h12);
    chk("vector", {8'hFC, 8'h01}, {stack_pointer_out, 7'h00, int_vector_ok});
  endtask
  initial begin
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    int_pending = 1'b0;
    opcode = 8'h00;
    operand1 = 8'h00;
    operand2 = 8'h00;
    index_r0 = 8'h08;
    index_r1 = 8'h24;
    rd_addr = 8'h00;
    rel_seen = 1'b0;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    for (int i = 0; i < 256; i++) ram[i] = i[7:0];
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset", 16'h0007, {acc_out, stack_pointer_out});
    t_or();
    t_rot();
    t_bit();
    t_stack();
    t_ret();
    end_sim();
  end
endmodule // testbench
bind cpu_slice cpu_slice_checker i_chk (.core_clk, .sys_rst, .instr_valid, .opcode, .operand1, .mem_rdata,
  .acc_out, .carry_out, .stack_pointer_out, .busy, .prio_release, .mem_we, .mem_waddr, .mem_wdata);
`default_nettype wire
